//--- verilog/avc_pkg.sv
package avc_pkg;
// Notes on behaviour
// RULE1: dac and adc run 8 to 48 khz, one shared sample rate field for both.
// RULE2: host supplies master clock at 256, 384 or 512 times lr clock.
// RULE3: internal clock is 22.5792 mhz or 24.576 mhz by rate family.
// RULE4: host mutes, powers down, changes clocks and fields, powers up, unmutes.
// RULE5: per channel dac volume 0 db to -63.5 db in 0.5 db steps.
// RULE6: each channel has its own mute bit in the dac volume register.
// RULE7: applied volume moves toward target at most once per 20 us.
// RULE8: slow select bit stretches the step interval to 40 us.
// RULE9: read-only done flag shows applied volume equals requested volume.
// RULE10: effects on/off change ramps to mute, switches, then ramps back.
// RULE11: power-up starts muted and ramps up; power-down ramps to mute first.
// RULE12: 48 khz family modulator runs at 6.144 mhz.
// RULE13: 44.1 khz family modulator runs at 5.6448 mhz.
// RULE14: interpolation rejects images 0.55 to 3.5 fs, flat passband; the code uses zero-order hold with no image filter.
// RULE15: dac path ends in fifth order one-bit delta-sigma modulator.
// RULE16: interpolator lifts rate-fs samples to the modulator stream rate.
// RULE17: host powers down analog bypass when unused with the dac.
// RULE18: audio serial port is slave only; host drives bit and lr clocks.
// RULE19: two-bit serial format field picks one of four formats.
// RULE20: port takes 32, 48 or 64 bit clocks per lr period; the code takes 32 only in the RJ16 format.
// RULE21: each tick moves applied code exactly one step, none once equal.
   localparam int CLK_HZ = 200000000;
   localparam int CLK_NS = 5;
   localparam int STEP_FAST_NS = 20000;
   localparam int STEP_SLOW_NS = 40000;
   localparam int STEP_FAST_CYC = (STEP_FAST_NS + CLK_NS - 1) / CLK_NS;
   localparam int STEP_SLOW_CYC = (STEP_SLOW_NS + CLK_NS - 1) / CLK_NS;
   localparam longint CORE_HZ_48 = 24576000;
   localparam longint CORE_HZ_44 = 22579200;
   localparam longint MOD_HZ_48 = CORE_HZ_48 / 4;
   localparam longint MOD_HZ_44 = CORE_HZ_44 / 4;
   localparam logic [31:0] NCO_INC_48 = 32'((MOD_HZ_48 << 32) / CLK_HZ);
   localparam logic [31:0] NCO_INC_44 = 32'((MOD_HZ_44 << 32) / CLK_HZ);
   localparam int SAMP_W = 20;
   localparam logic [3:0] PAGE_AUDIO = 4'h2;
   localparam logic [5:0] REG_FMT = 6'h00;
   localparam logic [5:0] REG_DAC_VOL = 6'h02;
   localparam logic [5:0] REG_SOFT = 6'h04;
   localparam logic [5:0] REG_PWR = 6'h05;
   localparam int CMD_RD = 15;
   localparam int CMD_PAGE_LSB = 11;
   localparam int CMD_ADDR_LSB = 5;
   localparam int FMT_LSB = 0;
   localparam int RATE_LSB = 2;
   localparam int VOL_L_MUTE = 15;
   localparam int VOL_L_LSB = 8;
   localparam int VOL_R_MUTE = 7;
   localparam int VOL_R_LSB = 0;
   localparam int SOFT_DONE = 0;
   localparam int SOFT_SLOW = 1;
   localparam int PWR_DEEMPH = 0;
   localparam int PWR_FILT = 1;
   localparam int PWR_ADC_PD = 9;
   localparam int PWR_DAC_PD = 10;
   localparam logic [15:0] FMT_RST = 16'h0000;
   localparam logic [15:0] VOL_RST = 16'h0000;
   localparam logic [15:0] PWR_RST = 16'h0600;
   localparam logic [15:0] PWR_MASK = 16'h0603;
   localparam logic [7:0] ATTN_MUTE = 8'h80;
   localparam logic [5:0] IN_RST = 6'h10;
   localparam int IN_SCLK = 5;
   localparam int IN_CSN = 4;
   localparam int IN_MOSI = 3;
   localparam int IN_BCLK = 2;
   localparam int IN_LR = 1;
   localparam int IN_DIN = 0;
   localparam logic [15:0] GAIN_TAB [12] = '{16'h8000, 16'h78d7, 16'h7215, 16'h6bb3,
      16'h65ad, 16'h5ffd, 16'h5a9e, 16'h558c, 16'h50c3, 16'h4c3f, 16'h47fb, 16'h43f4};
   typedef enum logic [3:0] {
      RATE_48 = 4'h0, RATE_44 = 4'h1, RATE_32 = 4'h2, RATE_24 = 4'h3, RATE_22 = 4'h4,
      RATE_16 = 4'h5, RATE_12 = 4'h6, RATE_11 = 4'h7, RATE_8 = 4'h8
   } avc_rate_t;
   typedef enum logic [1:0] {FMT_LJ = 2'b00, FMT_I2S = 2'b01, FMT_RJ16 = 2'b10, FMT_RJ20 = 2'b11} avc_fmt_t;
   typedef enum logic [1:0] {ST_OFF = 2'b00, ST_RUN = 2'b01, ST_FX = 2'b10, ST_DOWN = 2'b11} avc_state_t;
endpackage : avc_pkg

//--- verilog/avc_chan.sv
module avc_chan #(
   parameter int SAMP_W = avc_pkg::SAMP_W,
   parameter int ACC_W = 32
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic step_tick_in,
   input wire logic mod_tick_in,
   input wire logic hold_mute_in,
   input wire logic [7:0] target_in,
   input wire logic signed [SAMP_W-1:0] sample_in,
   output logic [7:0] attn_out,
   output logic at_target_out,
   output logic bit_out
);
   if (ACC_W < SAMP_W + 8) begin : g_chk
      $error("accumulator too narrow");
   end
   logic [7:0] attn_r, attn_nxt;
   logic at_r, at_nxt, bit_r, bit_nxt;
   logic signed [ACC_W-1:0] x_r, x_nxt, fb;
   logic signed [ACC_W-1:0] integ_r [5];
   logic signed [ACC_W-1:0] integ_nxt [5];
   logic signed [SAMP_W+16:0] prod;
   logic [3:0] mant, shamt;
   always_comb begin
      attn_nxt = attn_r;
      if (hold_mute_in) begin
         attn_nxt = avc_pkg::ATTN_MUTE; // see RULE11
      end else if (step_tick_in && attn_r < target_in) begin
         attn_nxt = attn_r + 8'h01; // see RULE21
      end else if (step_tick_in && attn_r > target_in) begin
         attn_nxt = attn_r - 8'h01; // see RULE21
      end
      at_nxt = (attn_nxt == target_in);
      // 12 half-db codes per 6 db: table for the fraction, shift for the octave
      mant = 4'(attn_r % 8'd12); // see RULE5
      shamt = 4'(attn_r / 8'd12);
      prod = sample_in * $signed({1'b0, avc_pkg::GAIN_TAB[mant]});
      x_nxt = x_r;
      if (mod_tick_in) begin
         // zero-order hold upsampling only; no image filter, see RULE14
         x_nxt = (attn_r == avc_pkg::ATTN_MUTE) ? '0 : ACC_W'(prod >>> (15 + shamt)); // see RULE16
      end
      fb = bit_r ? ACC_W'(1 <<< (SAMP_W - 1)) : -ACC_W'(1 <<< (SAMP_W - 1));
      for (int k = 0; k < 5; k++) begin
         integ_nxt[k] = integ_r[k];
      end
      bit_nxt = bit_r;
      if (mod_tick_in) begin
         // untuned loop coefficients: large inputs may overload the loop
         integ_nxt[0] = integ_r[0] + x_r - fb; // see RULE15
         for (int k = 1; k < 5; k++) begin
            integ_nxt[k] = integ_r[k] + (integ_r[k-1] >>> 2) - (fb >>> 2);
         end
         bit_nxt = ~integ_nxt[4][ACC_W-1];
      end
   end
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         attn_r <= avc_pkg::ATTN_MUTE;
         at_r <= 1'b0;
         bit_r <= 1'b0;
         x_r <= '0;
         for (int k = 0; k < 5; k++) begin
            integ_r[k] <= '0;
         end
      end else begin
         attn_r <= attn_nxt;
         at_r <= at_nxt;
         bit_r <= bit_nxt;
         x_r <= x_nxt;
         integ_r <= integ_nxt;
      end
   end
   assign attn_out = attn_r;
   assign at_target_out = at_r;
   assign bit_out = bit_r;

   property p_one_step;
      @(posedge clk_in) disable iff (rst_in)
      step_tick_in && !hold_mute_in && attn_r != target_in |=>
         (attn_r == $past(attn_r) + 8'h01) || (attn_r == $past(attn_r) - 8'h01);
   endproperty
   a_one_step: assert property (p_one_step) else $error("step not one code"); // see RULE21
   property p_no_tick_no_move;
      @(posedge clk_in) disable iff (rst_in)
      !step_tick_in && !hold_mute_in |=> $stable(attn_r);
   endproperty
   a_no_tick_no_move: assert property (p_no_tick_no_move) else $error("volume moved off tick"); // see RULE7
   property p_muted_silent;
      @(posedge clk_in) disable iff (rst_in)
      mod_tick_in && attn_r == avc_pkg::ATTN_MUTE |=> x_r == '0;
   endproperty
   a_muted_silent: assert property (p_muted_silent) else $error("muted channel not silent"); // see RULE6
endmodule : avc_chan

//--- verilog/avc_top.sv
module avc_top #(
   parameter int STEP_SLOW_CYC = avc_pkg::STEP_SLOW_CYC
) (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic spi_sclk_in,
   input wire logic spi_cs_n_in,
   input wire logic spi_mosi_in,
   output logic spi_miso_out,
   output logic spi_miso_oe_out,
   input wire logic i2s_bclk_in,
   input wire logic i2s_lrclk_in,
   input wire logic i2s_din_in,
   output logic dac_bit_l_out,
   output logic dac_bit_r_out,
   output logic dac_power_out,
   output logic adc_power_out,
   output logic deemph_on_out,
   output logic effects_on_out
);
   if (STEP_SLOW_CYC < avc_pkg::STEP_FAST_CYC || STEP_SLOW_CYC > 65535) begin : g_chk
      $error("slow step count out of range");
   end
   localparam logic [15:0] FAST_M1 = 16'(avc_pkg::STEP_FAST_CYC - 1);
   localparam logic [15:0] SLOW_M1 = 16'(STEP_SLOW_CYC - 1);

   // pin synchronisers: stage 3 and stage 2 must agree before a change counts
   logic [5:0] s1_r, s2_r, s3_r, flt_r, flt_d_r, flt_nxt;
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         flt_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : flt_r[i];
      end
   end
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         s1_r <= avc_pkg::IN_RST;
         s2_r <= avc_pkg::IN_RST;
         s3_r <= avc_pkg::IN_RST;
         flt_r <= avc_pkg::IN_RST;
         flt_d_r <= avc_pkg::IN_RST;
      end else begin
         s1_r <= {spi_sclk_in, spi_cs_n_in, spi_mosi_in, i2s_bclk_in, i2s_lrclk_in, i2s_din_in};
         s2_r <= s1_r;
         s3_r <= s2_r;
         flt_r <= flt_nxt;
         flt_d_r <= flt_r;
      end
   end
   logic sclk_rise, sclk_fall, cs_n, mosi, bclk_rise, lr, din;
   assign sclk_rise = flt_r[avc_pkg::IN_SCLK] & ~flt_d_r[avc_pkg::IN_SCLK];
   assign sclk_fall = ~flt_r[avc_pkg::IN_SCLK] & flt_d_r[avc_pkg::IN_SCLK];
   assign cs_n = flt_r[avc_pkg::IN_CSN];
   assign mosi = flt_r[avc_pkg::IN_MOSI];
   assign bclk_rise = flt_r[avc_pkg::IN_BCLK] & ~flt_d_r[avc_pkg::IN_BCLK]; // see RULE18
   assign lr = flt_r[avc_pkg::IN_LR];
   assign din = flt_r[avc_pkg::IN_DIN];

   // register file state
   logic [15:0] fmt_r, fmt_nxt, vol_r, vol_nxt, pwr_r, pwr_nxt;
   logic slow_r, slow_nxt, done_r;
   logic [7:0] attn_l, attn_r_ch;
   logic at_l, at_r_ch;
   avc_pkg::avc_state_t st_r, st_nxt;

   // spi slave, mode 0: 16-bit command then 16-bit data
   logic [5:0] spi_cnt_r, spi_cnt_nxt;
   logic [15:0] spi_sh_r, spi_sh_nxt, cmd_r, cmd_nxt, tx_r, tx_nxt, cmd_word, rd_data;
   logic miso_r, miso_nxt, wr_stb;
   localparam int CMD_PAGE_HI = avc_pkg::CMD_PAGE_LSB + 3;
   assign cmd_word = {spi_sh_r[14:0], mosi};
   always_comb begin
      rd_data = 16'h0000;
      if (cmd_word[CMD_PAGE_HI:avc_pkg::CMD_PAGE_LSB] == avc_pkg::PAGE_AUDIO) begin
         case (cmd_word[10:avc_pkg::CMD_ADDR_LSB])
            avc_pkg::REG_FMT: rd_data = fmt_r;
            avc_pkg::REG_DAC_VOL: rd_data = vol_r;
            avc_pkg::REG_SOFT: rd_data = 16'({slow_r, done_r}); // see RULE9
            avc_pkg::REG_PWR: rd_data = pwr_r;
            default: rd_data = 16'h0000;
         endcase
      end
      spi_cnt_nxt = spi_cnt_r;
      spi_sh_nxt = spi_sh_r;
      cmd_nxt = cmd_r;
      tx_nxt = tx_r;
      miso_nxt = miso_r;
      wr_stb = 1'b0;
      if (cs_n) begin
         spi_cnt_nxt = 6'h00;
      end else if (sclk_rise) begin
         spi_sh_nxt = cmd_word;
         spi_cnt_nxt = (spi_cnt_r == 6'h3f) ? spi_cnt_r : spi_cnt_r + 6'h01;
         if (spi_cnt_r == 6'h0f) begin
            cmd_nxt = cmd_word;
            tx_nxt = rd_data;
         end
         wr_stb = (spi_cnt_r == 6'h1f) && !cmd_r[avc_pkg::CMD_RD] &&
                  cmd_r[CMD_PAGE_HI:avc_pkg::CMD_PAGE_LSB] == avc_pkg::PAGE_AUDIO;
      end else if (sclk_fall && spi_cnt_r >= 6'h10) begin
         miso_nxt = tx_r[15];
         tx_nxt = {tx_r[14:0], 1'b0};
      end
   end
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         spi_cnt_r <= 6'h00;
         spi_sh_r <= 16'h0000;
         cmd_r <= 16'h0000;
         tx_r <= 16'h0000;
         miso_r <= 1'b0;
         spi_miso_oe_out <= 1'b0;
      end else begin
         spi_cnt_r <= spi_cnt_nxt;
         spi_sh_r <= spi_sh_nxt;
         cmd_r <= cmd_nxt;
         tx_r <= tx_nxt;
         miso_r <= miso_nxt;
         spi_miso_oe_out <= ~cs_n;
      end
   end
   assign spi_miso_out = miso_r;

   // register writes
   always_comb begin
      fmt_nxt = fmt_r;
      vol_nxt = vol_r;
      pwr_nxt = pwr_r;
      slow_nxt = slow_r;
      if (wr_stb) begin
         case (cmd_r[10:avc_pkg::CMD_ADDR_LSB])
            avc_pkg::REG_FMT: fmt_nxt = cmd_word & 16'h003f; // see RULE19
            avc_pkg::REG_DAC_VOL: vol_nxt = cmd_word; // see RULE5
            avc_pkg::REG_SOFT: slow_nxt = cmd_word[avc_pkg::SOFT_SLOW]; // see RULE8
            avc_pkg::REG_PWR: pwr_nxt = cmd_word & avc_pkg::PWR_MASK;
            default: fmt_nxt = fmt_r;
         endcase
      end
   end
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         fmt_r <= avc_pkg::FMT_RST;
         vol_r <= avc_pkg::VOL_RST;
         pwr_r <= avc_pkg::PWR_RST;
         slow_r <= 1'b0;
      end else begin
         fmt_r <= fmt_nxt;
         vol_r <= vol_nxt;
         pwr_r <= pwr_nxt;
         slow_r <= slow_nxt;
      end
   end
   logic [1:0] fmt;
   logic [3:0] rate;
   logic fam44;
   assign fmt = fmt_r[avc_pkg::FMT_LSB +: 2];
   assign rate = fmt_r[avc_pkg::RATE_LSB +: 4]; // see RULE1
   assign fam44 = rate == avc_pkg::RATE_44 || rate == avc_pkg::RATE_22 || rate == avc_pkg::RATE_11;

   // serial audio receive; 48/64 bit-clock frames work for every format, 32 only for RJ16; counts saturate
   logic lr_d_r, lr_d_nxt;
   logic [19:0] bsh_r, bsh_nxt, smp_l_r, smp_l_nxt, smp_r_r, smp_r_nxt, word;
   logic [6:0] bcnt_r, bcnt_nxt, wlen;
   logic rj, take, left;
   always_comb begin
      lr_d_nxt = lr_d_r;
      bsh_nxt = bsh_r;
      bcnt_nxt = bcnt_r;
      smp_l_nxt = smp_l_r;
      smp_r_nxt = smp_r_r;
      rj = fmt[1];
      wlen = (fmt == avc_pkg::FMT_RJ16) ? 7'd16 : 7'd20; // see RULE20
      word = 20'h00000;
      take = 1'b0;
      left = 1'b0;
      if (bclk_rise) begin
         lr_d_nxt = lr;
         bsh_nxt = {bsh_r[18:0], din};
         if (lr != lr_d_r) begin
            bcnt_nxt = 7'd1;
            take = rj;
            left = lr_d_r;
            word = (fmt == avc_pkg::FMT_RJ16) ? {bsh_r[15:0], 4'h0} : bsh_r;
         end else begin
            bcnt_nxt = (bcnt_r == 7'h7f) ? bcnt_r : bcnt_r + 7'd1;
            take = !rj && bcnt_nxt == wlen + 7'(fmt == avc_pkg::FMT_I2S);
            left = (fmt == avc_pkg::FMT_I2S) ? ~lr : lr;
            word = (fmt == avc_pkg::FMT_LJ) ? bsh_nxt : {bsh_nxt[15:0], 4'h0};
            word = (fmt == avc_pkg::FMT_LJ || fmt == avc_pkg::FMT_I2S) ? bsh_nxt : word;
         end
         if (take && left) begin
            smp_l_nxt = word;
         end
         if (take && !left) begin
            smp_r_nxt = word;
         end
      end
   end
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         lr_d_r <= 1'b0;
         bsh_r <= 20'h00000;
         bcnt_r <= 7'd0;
         smp_l_r <= 20'h00000;
         smp_r_r <= 20'h00000;
      end else begin
         lr_d_r <= lr_d_nxt;
         bsh_r <= bsh_nxt;
         bcnt_r <= bcnt_nxt;
         smp_l_r <= smp_l_nxt;
         smp_r_r <= smp_r_nxt;
      end
   end

   // step divider, modulator rate nco, power and effects sequencing
   logic [15:0] step_cnt_r, step_cnt_nxt;
   logic step_tick_r, step_tick_nxt, mod_tick_r, mod_tick_nxt, done_nxt;
   logic [31:0] nco_r, nco_nxt;
   logic [1:0] fx_r, fx_nxt, fx_req;
   logic muted, dac_pd;
   assign fx_req = {pwr_r[avc_pkg::PWR_FILT], pwr_r[avc_pkg::PWR_DEEMPH]};
   assign dac_pd = pwr_r[avc_pkg::PWR_DAC_PD];
   assign muted = attn_l == avc_pkg::ATTN_MUTE && attn_r_ch == avc_pkg::ATTN_MUTE;
   always_comb begin
      step_tick_nxt = step_cnt_r >= (slow_r ? SLOW_M1 : FAST_M1); // see RULE7 RULE8
      step_cnt_nxt = step_tick_nxt ? 16'h0000 : step_cnt_r + 16'h0001;
      // rate family picks the internal clock, modulator runs at a quarter of it
      {mod_tick_nxt, nco_nxt} = {1'b0, nco_r} +
         {1'b0, fam44 ? avc_pkg::NCO_INC_44 : avc_pkg::NCO_INC_48}; // see RULE3 RULE12 RULE13
      st_nxt = st_r;
      fx_nxt = fx_r;
      unique case (st_r)
         avc_pkg::ST_OFF: if (!dac_pd) st_nxt = avc_pkg::ST_RUN; // see RULE11
         avc_pkg::ST_RUN: begin
            if (dac_pd) begin
               st_nxt = avc_pkg::ST_DOWN;
            end else if (fx_req != fx_r) begin
               st_nxt = avc_pkg::ST_FX; // see RULE10
            end
         end
         avc_pkg::ST_FX: begin
            if (muted) begin
               fx_nxt = fx_req; // see RULE10
               st_nxt = avc_pkg::ST_RUN;
            end
         end
         avc_pkg::ST_DOWN: if (muted) st_nxt = avc_pkg::ST_OFF; // see RULE11
      endcase
      done_nxt = at_l && at_r_ch && (st_r == avc_pkg::ST_RUN || st_r == avc_pkg::ST_OFF); // see RULE9
   end
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         step_cnt_r <= 16'h0000;
         step_tick_r <= 1'b0;
         nco_r <= 32'h00000000;
         mod_tick_r <= 1'b0;
         st_r <= avc_pkg::ST_OFF;
         fx_r <= 2'b00;
         done_r <= 1'b0;
         dac_power_out <= 1'b0;
         adc_power_out <= 1'b0;
      end else begin
         step_cnt_r <= step_cnt_nxt;
         step_tick_r <= step_tick_nxt;
         nco_r <= nco_nxt;
         mod_tick_r <= mod_tick_nxt;
         st_r <= st_nxt;
         fx_r <= fx_nxt;
         done_r <= done_nxt;
         dac_power_out <= st_nxt != avc_pkg::ST_OFF;
         adc_power_out <= ~pwr_r[avc_pkg::PWR_ADC_PD];
      end
   end
   assign deemph_on_out = fx_r[0];
   assign effects_on_out = fx_r[1];

   logic [7:0] tgt_l, tgt_r;
   logic ramp_mute;
   assign ramp_mute = st_r != avc_pkg::ST_RUN;
   assign tgt_l = (ramp_mute || vol_r[avc_pkg::VOL_L_MUTE]) ? avc_pkg::ATTN_MUTE :
                  {1'b0, vol_r[avc_pkg::VOL_L_LSB +: 7]}; // see RULE6
   assign tgt_r = (ramp_mute || vol_r[avc_pkg::VOL_R_MUTE]) ? avc_pkg::ATTN_MUTE :
                  {1'b0, vol_r[avc_pkg::VOL_R_LSB +: 7]}; // see RULE6
   avc_chan u_left (.clk_in(sys_clk_in), .rst_in(rst_in), .step_tick_in(step_tick_r),
      .mod_tick_in(mod_tick_r), .hold_mute_in(st_r == avc_pkg::ST_OFF), .target_in(tgt_l),
      .sample_in(smp_l_r), .attn_out(attn_l), .at_target_out(at_l), .bit_out(dac_bit_l_out));
   avc_chan u_right (.clk_in(sys_clk_in), .rst_in(rst_in), .step_tick_in(step_tick_r),
      .mod_tick_in(mod_tick_r), .hold_mute_in(st_r == avc_pkg::ST_OFF), .target_in(tgt_r),
      .sample_in(smp_r_r), .attn_out(attn_r_ch), .at_target_out(at_r_ch), .bit_out(dac_bit_r_out));

   // helper gap counters watched only by the checks
   logic [15:0] tgap_r;
   logic [7:0] mgap_r;
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         tgap_r <= 16'h0000;
         mgap_r <= 8'h00;
      end else begin
         tgap_r <= step_tick_r ? 16'h0000 : tgap_r + 16'h0001;
         mgap_r <= mod_tick_r ? 8'h00 : mgap_r + 8'h01;
      end
   end
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   property p_tick_gap;
      step_tick_r && $past(step_tick_r, 2) == 1'b0 && !$rose(step_tick_r) == 1'b0 |-> tgap_r >= FAST_M1;
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("step ticks too close"); // see RULE7
   property p_slow_gap;
      step_tick_r && slow_r && $past(slow_r) |-> tgap_r >= SLOW_M1 && step_cnt_r == 16'h0000;
   endproperty
   a_slow_gap: assert property (p_slow_gap) else $error("slow tick gap wrong"); // see RULE8
   property p_done;
      done_r |-> $past(attn_l) == $past(tgt_l, 2) && $past(attn_r_ch) == $past(tgt_r, 2);
   endproperty
   a_done: assert property (p_done) else $error("done flag early"); // see RULE9
   property p_fx_when_muted;
      fx_r != $past(fx_r) |-> $past(muted);
   endproperty
   a_fx_when_muted: assert property (p_fx_when_muted) else $error("effects switched unmuted"); // see RULE10
   property p_power_off_muted;
      $fell(dac_power_out) |-> muted;
   endproperty
   a_power_off_muted: assert property (p_power_off_muted) else $error("power cut before mute"); // see RULE11
   property p_mod_rate;
      mod_tick_r && $past(mod_tick_r, 40) == 1'b0 ##0 mgap_r != 8'h00 |-> mgap_r >= 8'd31 && mgap_r <= 8'd35;
   endproperty
   a_mod_rate: assert property (p_mod_rate) else $error("modulator tick rate off"); // see RULE12
   property p_fmt_write;
      wr_stb && cmd_r[10:avc_pkg::CMD_ADDR_LSB] == avc_pkg::REG_FMT |=> fmt == $past(cmd_word[1:0]);
   endproperty
   a_fmt_write: assert property (p_fmt_write) else $error("format field not stored"); // see RULE19
   property p_start_muted;
      $rose(dac_power_out) |-> attn_l == avc_pkg::ATTN_MUTE && attn_r_ch == avc_pkg::ATTN_MUTE;
   endproperty
   a_start_muted: assert property (p_start_muted) else $error("power-up not muted"); // see RULE11
   c_fx_cycle: cover property (st_r == avc_pkg::ST_FX ##[1:1000] st_r == avc_pkg::ST_RUN);
   c_power_down: cover property (st_r == avc_pkg::ST_DOWN ##[1:1000] st_r == avc_pkg::ST_OFF);
   c_done_rise: cover property ($rose(done_r));
endmodule : avc_top

//--- tb/avc_host.sv
module avc_host (
   input wire logic clk_in,
   input wire logic miso_in,
   output logic sclk_out,
   output logic cs_n_out,
   output logic mosi_out,
   output logic bclk_out,
   output logic lrclk_out,
   output logic din_out
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      mosi_out = 1'b0;
   end
   // host makes both audio clocks
   // bit and lr clocks derive from one host clock
   // 64 bit clocks a frame, 20-bit left-justified words
   initial begin : audio
      int b;
      bclk_out = 1'b0;
      lrclk_out = 1'b0;
      din_out = 1'b0;
      forever for (b = 0; b < 64; b++) begin
         repeat (30) @(posedge clk_in);
         #1 bclk_out = 1'b0;
         lrclk_out = (b < 32);
         din_out = (b == 1) || (b == 33);
         repeat (30) @(posedge clk_in);
         #1 bclk_out = 1'b1;
      end
   end
   // sclk period 125 ns, idle low between frames
   task automatic xfer(input logic [31:0] frame, output logic [15:0] rd);
      int i;
      rd = 16'h0000;
      // chip select must stay high long enough to pass the pin filter
      repeat (8) @(posedge clk_in);
      #1 cs_n_out = 1'b0;
      for (i = 31; i >= 0; i--) begin
         mosi_out = frame[i];
         repeat (13) @(posedge clk_in);
         #1 sclk_out = 1'b1;
         if (i < 16) rd = {rd[14:0], miso_in};
         repeat (12) @(posedge clk_in);
         #1 sclk_out = 1'b0;
      end
      repeat (13) @(posedge clk_in);
      #1 cs_n_out = 1'b1;
      mosi_out = ~mosi_out;
   endtask : xfer
endmodule : avc_host

//--- tb/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic sclk, cs_n, mosi, miso, miso_oe, bclk, lrclk, din;
   logic bit_l, bit_r, dac_pwr, adc_pwr, deemph, fx;
   logic [15:0] d;
   int errors = 0;
   int n_tests = 0;
   int cyc = 0;
   int flips = 0;
   int t0, i, f0;
   // undriven miso floats so a stray read is caught
   wire miso_w = miso_oe ? miso : 1'bz;
   always #2.5 sys_clk_in = ~sys_clk_in;
   always @(posedge sys_clk_in) cyc <= cyc + 1;
   always @(bit_r) flips++;
   avc_host host (.clk_in(sys_clk_in), .miso_in(miso_w), .sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi),
      .bclk_out(bclk), .lrclk_out(lrclk), .din_out(din));
   avc_top DUT (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .spi_sclk_in(sclk), .spi_cs_n_in(cs_n),
      .spi_mosi_in(mosi), .spi_miso_out(miso), .spi_miso_oe_out(miso_oe), .i2s_bclk_in(bclk),
      .i2s_lrclk_in(lrclk), .i2s_din_in(din), .dac_bit_l_out(bit_l), .dac_bit_r_out(bit_r),
      .dac_power_out(dac_pwr), .adc_power_out(adc_pwr), .deemph_on_out(deemph), .effects_on_out(fx));
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: word %h expected %h", $time, got, exp);
      end
   endtask : chk_word
   task automatic chk_pin(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: bit %b expected %b", $time, got, exp);
      end
   endtask : chk_pin
   task automatic wr(input logic [3:0] pg, input logic [5:0] a, input logic [15:0] v);
      host.xfer({1'b0, pg, a, 5'h00, v}, d);
   endtask : wr
   task automatic rd(input logic [5:0] a, input logic [15:0] m, input logic [15:0] exp);
      host.xfer({1'b1, 4'h2, a, 5'h00, 16'h0000}, d);
      chk_word(d & m, exp);
   endtask : rd
   // poll the done flag; elapsed cycles must fall in lo..hi
   task automatic wait_done(input int lo, input int hi);
      t0 = cyc;
      for (i = 0; i < 60; i++) begin
         host.xfer({1'b1, 4'h2, 6'h04, 5'h00, 16'h0000}, d);
         if (d[0] === 1'b1) break;
      end
      if (d[0] !== 1'b1) begin
         errors++;
         $display("mismatch at %0t: done flag never set", $time);
         test_done;
      end
      chk_pin(cyc - t0 >= lo && cyc - t0 <= hi, 1'b1);
   endtask : wait_done
   task automatic test_done;
      $display("errors %0d of %0d compares", errors, n_tests);
      if (errors == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : test_done
   initial begin
      repeat (4) @(posedge sys_clk_in);
      #1 rst_in = 1'b0;
      chk_pin(dac_pwr, 1'b0);
      chk_pin(adc_pwr, 1'b0);
      rd(6'h05, 16'hffff, 16'h0600);
      rd(6'h02, 16'hffff, 16'h0000);
      // rate and format set while powered down
      for (int k = 0; k < 9; k++) begin
         wr(4'h2, 6'h00, 16'(k * 4 + k % 4));
         rd(6'h00, 16'h003f, 16'(k * 4 + k % 4));
      end
      wr(4'h2, 6'h00, 16'h0000);
      rd(6'h00, 16'h0003, 16'h0000);
      wr(4'h2, 6'h02, 16'h807e);
      wr(4'h1, 6'h02, 16'hffff);
      rd(6'h02, 16'hffff, 16'h807e);
      rd(6'h3f, 16'hffff, 16'h0000);
      wr(4'h2, 6'h04, 16'h0003);
      rd(6'h04, 16'h0002, 16'h0002);
      wr(4'h2, 6'h05, 16'h0000);
      chk_pin(dac_pwr, 1'b1);
      chk_pin(adc_pwr, 1'b1);
      // left muted alone, right ramps mute to 7e in two slow steps
      wait_done(8000, 26000);
      f0 = flips;
      wr(4'h2, 6'h04, 16'h0000);
      wr(4'h2, 6'h02, 16'h807c);
      wait_done(4000, 14000);
      chk_pin(flips != f0, 1'b1);
      wr(4'h2, 6'h05, 16'h0002);
      chk_pin(fx, 1'b0);
      // four steps down to mute, switch, four steps back up
      wait_done(28000, 34000);
      chk_pin(fx, 1'b1);
      chk_pin(deemph, 1'b0);
      wr(4'h2, 6'h05, 16'h0602);
      chk_pin(dac_pwr, 1'b1);
      chk_pin(adc_pwr, 1'b0);
      for (i = 0; i < 20000 && dac_pwr !== 1'b0; i++) @(posedge sys_clk_in);
      chk_pin(dac_pwr, 1'b0);
      test_done;
   end
endmodule : tb
